// ### src/prio_map_defs.vh
`ifndef PRIO_MAP_DEFS_VH
`define PRIO_MAP_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PCP_LOW_QUEUE_MAP_ADDR 8'h80
`define PCP_HIGH_QUEUE_MAP_ADDR 8'h81
`define TWO_QUEUE_SPLIT_CTRL_ADDR 8'h82
`define UNKNOWN_UNICAST_FORWARD_CTRL_ADDR 8'h83

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PCP_LOW_QUEUE_MAP_RESET 8'h50
`define PCP_HIGH_QUEUE_MAP_RESET 8'hFA
`define TWO_QUEUE_SPLIT_SELECT_RESET 2'h2
`define TWO_QUEUE_SPLIT_RSVD_VALUE 6'h08
`define UU_FORWARD_RSVD_VALUE 2'h2
`define UU_FORWARD_ENABLE_RESET 1'h0
`define UU_FORWARD_PORT_MAP_RESET 5'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CLASS_FIELD_WIDTH 2
`define SPLIT_SELECT_MSB 7
`define SPLIT_SELECT_LSB 6
`define UU_FORWARD_ENABLE_BIT 5
`define UU_FORWARD_PORT_MAP_MSB 4
`define UU_FORWARD_PORT_MAP_LSB 0

// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define CLASS_LOWEST 2'h0
`define CLASS_HIGHEST 2'h3
`define SPLIT_SEL_LOW3 2'h0
`define SPLIT_SEL_UNSUPPORTED 2'h1
`define SPLIT_SEL_LOW2 2'h2
`define SPLIT_SEL_LOW1 2'h3

`endif

// ### src/two_queue_fold.v
`timescale 1ns/1ns
`include "prio_map_defs.vh"

module two_queue_fold (
    // Four-queue class in
    input wire [1:0] queue_class,
    // Split selector
    input wire [1:0] two_queue_split_select,
    // Folded result, 1 = high queue
    output reg queue_high
);

    always @* begin
        // Class 3 always high, class 0 always low
        if (queue_class == `CLASS_HIGHEST) begin
            queue_high = 1'b1;
        end else if (queue_class == `CLASS_LOWEST) begin
            queue_high = 1'b0;
        end else begin
            case (two_queue_split_select)
                `SPLIT_SEL_LOW3: begin
                    queue_high = 1'b0;
                end
                `SPLIT_SEL_LOW2: begin
                    queue_high = queue_class[1];
                end
                `SPLIT_SEL_LOW1: begin
                    queue_high = 1'b1;
                end
                default: begin
                    // Unsupported 01 behaves as the reset split
                    queue_high = queue_class[1];
                end
            endcase
        end
    end

endmodule // two_queue_fold

// ### src/prio_queue_map.v
`timescale 1ns/1ns
`include "prio_map_defs.vh"

module prio_queue_map (
    // Clock, reset, enable
    input wire clk,
    input wire rst_n,
    input wire ce,
    // Register port
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Frame classification
    input wire frame_valid,
    input wire [2:0] frame_pcp,
    input wire use_tos_class,
    input wire [1:0] tos_class,
    input wire two_queue_mode,
    output reg class_valid,
    output reg [1:0] queue_class,
    output reg queue_high,
    // Unknown unicast decision
    input wire uu_lookup_miss,
    output reg uu_valid,
    output reg uu_forward_override,
    output reg uu_discard,
    output reg [4:0] uu_forward_ports
);

    reg [7:0] pcp_low_queue_map;
    reg [7:0] pcp_high_queue_map;
    reg [1:0] two_queue_split_select;
    reg uu_forward_enable;
    reg [4:0] uu_forward_port_map;
    wire [15:0] pcp_class_bus;
    wire [1:0] class_table [0:7];
    wire [1:0] next_queue_class;
    wire fold_high;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Reserved bits hold no state; they read back as constants.
    always @(posedge clk) begin
        if (!rst_n) begin
            pcp_low_queue_map <= `PCP_LOW_QUEUE_MAP_RESET;
            pcp_high_queue_map <= `PCP_HIGH_QUEUE_MAP_RESET;
            two_queue_split_select <= `TWO_QUEUE_SPLIT_SELECT_RESET;
            uu_forward_enable <= `UU_FORWARD_ENABLE_RESET;
            uu_forward_port_map <= `UU_FORWARD_PORT_MAP_RESET;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `PCP_LOW_QUEUE_MAP_ADDR: begin
                    pcp_low_queue_map <= reg_wdata;
                end
                `PCP_HIGH_QUEUE_MAP_ADDR: begin
                    pcp_high_queue_map <= reg_wdata;
                end
                `TWO_QUEUE_SPLIT_CTRL_ADDR: begin
                    two_queue_split_select <=
                        reg_wdata[`SPLIT_SELECT_MSB:`SPLIT_SELECT_LSB];
                end
                `UNKNOWN_UNICAST_FORWARD_CTRL_ADDR: begin
                    uu_forward_enable <= reg_wdata[`UU_FORWARD_ENABLE_BIT];
                    uu_forward_port_map <= reg_wdata[
                        `UU_FORWARD_PORT_MAP_MSB:`UU_FORWARD_PORT_MAP_LSB];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Registered so read data follows the address by one cycle.
    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            case (reg_addr)
                `PCP_LOW_QUEUE_MAP_ADDR: begin
                    reg_rdata <= pcp_low_queue_map;
                end
                `PCP_HIGH_QUEUE_MAP_ADDR: begin
                    reg_rdata <= pcp_high_queue_map;
                end
                `TWO_QUEUE_SPLIT_CTRL_ADDR: begin
                    reg_rdata <= {two_queue_split_select,
                                  `TWO_QUEUE_SPLIT_RSVD_VALUE};
                end
                `UNKNOWN_UNICAST_FORWARD_CTRL_ADDR: begin
                    reg_rdata <= {`UU_FORWARD_RSVD_VALUE, uu_forward_enable,
                                  uu_forward_port_map};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // PCP to class lookup
    // ------------------------------------------------------------
    assign pcp_class_bus = {pcp_high_queue_map, pcp_low_queue_map};

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pcp
            // Field i sits at bits 2i+1:2i of the combined map
            assign class_table[i] = pcp_class_bus[
                i*`CLASS_FIELD_WIDTH +: `CLASS_FIELD_WIDTH];
        end
    endgenerate

    // TOS class, when chosen upstream, bypasses the PCP table
    assign next_queue_class = use_tos_class ? tos_class
                                            : class_table[frame_pcp];

    two_queue_fold u_fold (
        .queue_class(next_queue_class),
        .two_queue_split_select(two_queue_split_select),
        .queue_high(fold_high)
    );

    // ------------------------------------------------------------
    // Classification outputs
    // ------------------------------------------------------------
    // Class 3 is the most urgent queue for the scheduler downstream.
    always @(posedge clk) begin
        if (!rst_n) begin
            class_valid <= 1'b0;
            queue_class <= `CLASS_LOWEST;
            queue_high <= 1'b0;
        end else if (ce) begin
            class_valid <= frame_valid;
            if (frame_valid) begin
                queue_class <= next_queue_class;
                queue_high <= two_queue_mode & fold_high;
            end
        end
    end

    // ------------------------------------------------------------
    // Unknown unicast decision
    // ------------------------------------------------------------
    // Map bits go straight to ports, so the listed patterns and any
    // other pattern share one path; 11111 covers every port.
    always @(posedge clk) begin
        if (!rst_n) begin
            uu_valid <= 1'b0;
            uu_forward_override <= 1'b0;
            uu_discard <= 1'b0;
            uu_forward_ports <= 5'h00;
        end else if (ce) begin
            uu_valid <= uu_lookup_miss;
            if (uu_lookup_miss) begin
                uu_forward_override <= uu_forward_enable;
                uu_discard <= uu_forward_enable &
                              (uu_forward_port_map == 5'h00);
                uu_forward_ports <= uu_forward_enable ?
                    uu_forward_port_map : 5'h00;
            end
        end
    end

endmodule // prio_queue_map

// ### tb/prio_map_props.sv
`timescale 1ns/1ns
module prio_map_props (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // Classifier side
    input wire frame_valid,
    input wire use_tos_class,
    input wire [1:0] tos_class,
    input wire two_queue_mode,
    input wire class_valid,
    input wire [1:0] queue_class,
    input wire queue_high,
    // Unknown unicast side
    input wire uu_lookup_miss,
    input wire uu_valid,
    input wire uu_forward_override,
    input wire uu_discard,
    input wire [4:0] uu_forward_ports
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Folding is judged on TOS input so the expected class is known here
    wire tos_fr = ce && frame_valid && use_tos_class && two_queue_mode;
    a_class_pulse: assert property (ce && frame_valid |=> class_valid)
        else $error("class_valid missing");
    a_tos_pass: assert property (tos_fr |=> queue_class == $past(tos_class))
        else $error("class not taken from tos");
    a_one_queue_low: assert property (
        ce && frame_valid && !two_queue_mode |=> !queue_high)
        else $error("high queue outside two-queue mode");
    a_top_class_high: assert property (
        tos_fr && tos_class == 2'h3 |=> queue_high)
        else $error("class 3 not high");
    a_bottom_class_low: assert property (
        tos_fr && tos_class == 2'h0 |=> !queue_high)
        else $error("class 0 not low");
    a_uu_pulse: assert property (ce && uu_lookup_miss |=> uu_valid)
        else $error("uu_valid missing");
    a_uu_off_quiet: assert property (uu_valid && !uu_forward_override
        |-> uu_forward_ports == 5'h00 && !uu_discard)
        else $error("forwarding while disabled");
    a_discard_empty: assert property (uu_valid && uu_forward_override
        |-> uu_discard == (uu_forward_ports == 5'h00))
        else $error("discard does not match empty map");
    cover property (tos_fr && tos_class == 2'h1);
    cover property (uu_valid && uu_discard);
    cover property (uu_valid && uu_forward_ports == 5'h1F);
endmodule // prio_map_props

bind prio_queue_map prio_map_props chk (.*);

// ### tb/tb_prio_queue_map.sv
`timescale 1ns/1ns
module tb_prio_queue_map;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    reg ce = 1'h1;
    reg [7:0] reg_addr = 8'h00;
    reg reg_wr = 1'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg frame_valid = 1'h0;
    reg [2:0] frame_pcp = 3'h0;
    reg use_tos_class = 1'h0;
    reg [1:0] tos_class = 2'h0;
    reg two_queue_mode = 1'h1;
    reg uu_lookup_miss = 1'h0;
    wire [7:0] reg_rdata;
    wire class_valid, queue_high, uu_valid, uu_forward_override, uu_discard;
    wire [1:0] queue_class;
    wire [4:0] uu_forward_ports;
    reg [7:0] v;
    reg [1:0] c;
    integer mismatches = 0;
    integer n_checks = 0;
    integer i, s;
    always #5 clk = ~clk;
    prio_queue_map uut (.*);
    // ------------------------------------------------------------
    // Bus and frame helpers, all driven on the falling edge
    // ------------------------------------------------------------
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'h1;
            @(negedge clk);
            reg_wr = 1'h0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(negedge clk);
            reg_addr = a;
            @(negedge clk);
            v = reg_rdata;
        end
    endtask
    task cls(input tos, input [2:0] p, input [1:0] t);
        begin
            @(negedge clk);
            frame_valid = 1'h1;
            use_tos_class = tos;
            frame_pcp = p;
            tos_class = t;
            @(negedge clk);
            frame_valid = 1'h0;
            v = {4'h0, class_valid, queue_high, queue_class};
        end
    endtask
    task uu_case(input en, input [4:0] m);
        begin
            wr(8'h83, {2'h1, en, m});
            rd(8'h83);
            chk(v, {2'h2, en, m});
            @(negedge clk);
            uu_lookup_miss = 1'h1;
            @(negedge clk);
            uu_lookup_miss = 1'h0;
            v = {uu_valid, uu_forward_override, uu_discard, uu_forward_ports};
            chk(v, en ? {2'h3, m == 5'h00, m} : 8'h80);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_pcp_map;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                cls(1'h0, i[2:0], 2'h0);
                chk(v, {5'h01, i[2:1] >= 2'h2, i[2:1]});
            end
            wr(8'h80, 8'h1B);
            wr(8'h81, 8'hE4);
            rd(8'h80);
            chk(v, 8'h1B);
            rd(8'h81);
            chk(v, 8'hE4);
            for (i = 0; i < 8; i = i + 1) begin
                c = i[2] ? i[1:0] : ~i[1:0];
                cls(1'h0, i[2:0], 2'h0);
                chk(v, {5'h01, c >= 2'h2, c});
            end
            two_queue_mode = 1'h0;
            cls(1'h0, 3'h7, 2'h0);
            chk(v, 8'h0B);
            two_queue_mode = 1'h1;
        end
    endtask
    task t_split;
        begin
            rd(8'h82);
            chk(v, 8'h88);
            // Selector 01 is skipped: it is unsupported and folds as the reset split 10
            for (s = 0; s < 4; s = s + 1) if (s != 1) begin
                wr(8'h82, {s[1:0], 6'h37});
                rd(8'h82);
                chk(v, {s[1:0], 6'h08});
                for (i = 0; i < 4; i = i + 1) begin
                    cls(1'h1, 3'h0, i[1:0]);
                    chk(v, {5'h01, i >= (s == 0 ? 3 : 4 - s), i[1:0]});
                end
            end
        end
    endtask
    task t_uu;
        begin
            rd(8'h83);
            chk(v, 8'h80);
            uu_case(1'h1, 5'h00);
            uu_case(1'h1, 5'h01);
            uu_case(1'h1, 5'h03);
            uu_case(1'h1, 5'h07);
            uu_case(1'h1, 5'h0F);
            uu_case(1'h1, 5'h1F);
            uu_case(1'h1, 5'h0A);
            uu_case(1'h0, 5'h1F);
        end
    endtask
    // Clock enable low must swallow a write; reset mid-run restores maps
    task t_hold;
        begin
            @(negedge clk);
            ce = 1'h0;
            reg_addr = 8'h80;
            reg_wdata = 8'h00;
            reg_wr = 1'h1;
            @(negedge clk);
            reg_wr = 1'h0;
            ce = 1'h1;
            rd(8'h80);
            chk(v, 8'h1B);
            rd(8'h84);
            chk(v, 8'h00);
            @(negedge clk);
            rst_n = 1'h0;
            repeat (2) @(negedge clk);
            rst_n = 1'h1;
            rd(8'h80);
            chk(v, 8'h50);
            rd(8'h81);
            chk(v, 8'hFA);
            rd(8'h83);
            chk(v, 8'h80);
        end
    endtask
    task summarize;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        t_pcp_map;
        t_split;
        t_uu;
        t_hold;
        summarize;
    end
    // Whole run needs about 150 cycles; this allows ample margin
    initial begin
        #20000;
        mismatches = mismatches + 1;
        summarize;
    end
endmodule // tb_prio_queue_map
